/* File: sim/test_usb_host_cpu_bus_dma_port.sv */
`default_nettype none
// Both ends joined over the processor bus, driven from APB and the core side
module test_usb_host_cpu_bus_dma_port;
    timeunit 1ns;
    timeprecision 1ps;
    import uhp_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, cmd_v, wd_v, rd_take, done;
    logic [15:0] cmd, wd, last_cmd, last_wd;
    uhp_word_t rdata_in = 16'hbeef;
    logic want = 1'b0, rd = 1'b0, dma_request_high = 1'b1;
    logic irq_ev = 1'b0, irq_edge = 1'b0, irq_high = 1'b1;
    uhp_dma_mode_t mode = UHP_DMA_SINGLE;
    uhp_dma_mode_t bmodes [2] = '{UHP_DMA_BURST4, UHP_DMA_BURST8};
    int fail_count = 0, samples_checked = 0, cycles = 0;
    int cmd_n = 0, wd_n = 0, rd_n = 0, done_n = 0, base, act, n;
    uhp_bus_if bus ();
    uhp_device i_uhp_device (.i_clock(i_clock), .i_rst_b(i_rst_b), .bus(bus.device),
        .o_cmd_valid(cmd_v), .o_cmd(cmd), .o_wdata_valid(wd_v), .o_wdata(wd),
        .o_rdata_take(rd_take), .i_rdata(rdata_in), .i_dma_want(want), .i_dma_read(rd),
        .i_dma_mode(mode), .i_dma_request_active_high(dma_request_high), .i_irq_event(irq_ev),
        .i_irq_edge(irq_edge), .i_irq_active_high(irq_high), .o_dma_done(done));
    uhp_host i_uhp_host (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .bus(bus.host));
    uhp_properties i_uhp_properties (.i_clock(i_clock), .i_rst_b(i_rst_b), .cs_n(bus.cs_n),
        .rd_n(bus.rd_n), .wr_n(bus.wr_n), .dev_data_oe_n(bus.dev_data_oe_n),
        .dma_request(bus.dma_request), .dma_ack_low(bus.dma_ack_low),
        .transfer_end_in_n(bus.transfer_end_in_n), .rst_n(bus.rst_n),
        .i_dma_request_active_high(dma_request_high), .i_dma_read(rd), .i_dma_mode(mode));
    always #2.5 i_clock = ~i_clock;
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer; the leading edge keeps the previous release apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1) @(posedge i_clock);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Start a host operation and poll busy until it clears
    task automatic run(input logic [31:0] ctrl);
        apb(1'b1, 8'h00, ctrl);
        q = 32'h1;
        while (q[0] === 1'b1) apb(1'b0, 8'h08, 32'h0);
    endtask : run
    // Core-side event counters, plus the hang limit
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cmd_v === 1'b1) cmd_n <= cmd_n + 1;
        if (cmd_v === 1'b1) last_cmd <= cmd;
        if (wd_v === 1'b1) wd_n <= wd_n + 1;
        if (wd_v === 1'b1) last_wd <= wd;
        if (rd_take === 1'b1) rd_n <= rd_n + 1;
        if (done === 1'b1) done_n <= done_n + 1;
        if (cycles == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge i_clock);
        i_rst_b <= 1'b1;
        // Command write, then data write, then reads from both ports
        apb(1'b1, 8'h04, 32'h0000a5c3);
        run(32'h05);
        check("cmd word", last_cmd, 32'ha5c3);
        check("data writes", wd_n, 0);
        apb(1'b1, 8'h04, 32'h00003c5a);
        run(32'h01);
        check("data word", last_wd, 32'h3c5a);
        check("cmd writes", cmd_n, 1);
        run(32'h03);
        apb(1'b0, 8'h0c, 32'h0);
        check("data read", q, 32'hbeef);
        run(32'h07);
        apb(1'b0, 8'h0c, 32'h0);
        check("cmd read", q, 32'ha5c3);
        check("data takes", rd_n, 1);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped", q, 32'h0);
        // Single-cycle writes at both request levels, two in a row
        for (int p = 0; p < 2; p++) begin
            dma_request_high <= p[0];
            want <= 1'b1;
            repeat (20) @(posedge i_clock);
            check("request level", bus.dma_request, p[0]);
            base = wd_n;
            run(p[0] ? 32'h09 : 32'h109);
            run(p[0] ? 32'h09 : 32'h109);
            check("single writes", wd_n - base, 2);
            want <= 1'b0;
            repeat (70) @(posedge i_clock);
        end
        // Bursts of both lengths in both directions, two per setting
        for (int i = 0; i < 4; i++) begin
            mode <= bmodes[i % 2];
            rd <= i[1];
            want <= 1'b1;
            n = (bmodes[i % 2] == UHP_DMA_BURST8) ? 16 : 8;
            base = i[1] ? rd_n : wd_n;
            run(32'h09 | (i[1] ? 32'h02 : 32'h0) | (32'(bmodes[i % 2]) << 6));
            run(32'h09 | (i[1] ? 32'h02 : 32'h0) | (32'(bmodes[i % 2]) << 6));
            check("burst words", (i[1] ? rd_n : wd_n) - base, n);
            want <= 1'b0;
            repeat (70) @(posedge i_clock);
        end
        // End of transfer raised on the last strobe of a 4-word write burst
        mode <= UHP_DMA_BURST4;
        rd <= 1'b0;
        want <= 1'b1;
        base = done_n;
        run(32'h59);
        check("transfer end", done_n > base, 1);
        want <= 1'b0;
        repeat (70) @(posedge i_clock);
        // Device reset from the host silences a standing request
        mode <= UHP_DMA_SINGLE;
        want <= 1'b1;
        apb(1'b1, 8'h00, 32'h20);
        repeat (10) @(posedge i_clock);
        check("request in reset", bus.dma_request, 0);
        apb(1'b1, 8'h00, 32'h00);
        repeat (20) @(posedge i_clock);
        check("request after reset", bus.dma_request, 1);
        want <= 1'b0;
        // Interrupt in all four level, edge and polarity settings
        for (int c = 0; c < 4; c++) begin
            irq_edge <= c[1];
            irq_high <= c[0];
            repeat (6) @(posedge i_clock);
            check("irq idle", bus.irq, !c[0]);
            irq_ev <= 1'b1;
            act = 0;
            repeat (12) @(posedge i_clock) act += (bus.irq === c[0]);
            if (c[1]) check("irq pulse", act, 1);
            else check("irq level", bus.irq, c[0]);
            irq_ev <= 1'b0;
            repeat (12) @(posedge i_clock);
        end
        tally_and_finish();
    end
endmodule : test_usb_host_cpu_bus_dma_port
`default_nettype wire

/* File: sim/uhp_properties.sv */
`default_nettype none
// Watches the processor bus between both ends; figures are whole 5 ns cycles
module uhp_properties (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Bus signals
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic dev_data_oe_n,
    input wire logic dma_request,
    input wire logic dma_ack_low,
    input wire logic transfer_end_in_n,
    input wire logic rst_n,
    // Device configuration
    input wire logic i_dma_request_active_high,
    input wire logic i_dma_read,
    input wire uhp_pkg::uhp_dma_mode_t i_dma_mode
);
    import uhp_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    logic req_on;
    logic burst;
    logic strobe;
    logic strobe_q;
    logic [3:0] strobe_cnt;
    logic [5:0] gap_cnt;
    logic [5:0] off_cnt;
    logic [5:0] space_min;
    // Request seen at its programmed active level
    assign req_on = (dma_request == i_dma_request_active_high);
    assign burst = (i_dma_mode != UHP_DMA_SINGLE);
    assign strobe = !rd_n || !wr_n;
    // Least spacing between burst requests, rounded up to cycles
    assign space_min = (i_dma_mode == UHP_DMA_BURST8) ? (i_dma_read ? 6'h1e : 6'h22)
        : (i_dma_read ? 6'h15 : 6'h0f);
    // Saturating gap counters, so a long idle never wraps into a false short gap
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gap_cnt <= 6'h3f;
            off_cnt <= 6'h3f;
            strobe_cnt <= 4'h0;
            strobe_q <= 1'b0;
        end else begin
            gap_cnt <= !dma_ack_low ? 6'h00 : (gap_cnt == 6'h3f ? gap_cnt : gap_cnt + 6'h01);
            off_cnt <= req_on ? 6'h00 : (off_cnt == 6'h3f ? off_cnt : off_cnt + 6'h01);
            strobe_q <= strobe;
            strobe_cnt <= dma_ack_low ? 4'h0 : strobe_cnt + {3'h0, strobe && !strobe_q};
        end
    end
    // Burst request holds past 22 ns, then drops by 64 ns
    sequence req_held_then_drop;
        req_on [*4] ##[1:8] !req_on;
    endsequence
    drive_late_a: assert property ($fell(rd_n) && !cs_n && rst_n |-> ##[1:6] !dev_data_oe_n)
        else $error("read data late");
    release_late_a: assert property ($rose(rd_n) |-> ##[0:4] dev_data_oe_n)
        else $error("read data not released");
    unselected_drive_a: assert property ((cs_n && dma_ack_low) [*6] |-> dev_data_oe_n)
        else $error("bus driven while not selected");
    ack_drop_a: assert property (!burst && $fell(dma_ack_low) |-> ##[0:4] !req_on)
        else $error("single request not withdrawn");
    rerequest_gap_a: assert property (!burst && $rose(req_on) |-> gap_cnt >= 6'h0f)
        else $error("single request too soon");
    burst_drop_a:
        assert property (burst && req_on && !dma_ack_low && $rose(strobe) |-> ##1 req_held_then_drop)
        else $error("burst request drop out of window");
    burst_space_a: assert property (burst && $rose(req_on) |-> off_cnt >= space_min)
        else $error("burst requests too close");
    burst_count_a:
        assert property (burst && $rose(dma_ack_low)
            |-> strobe_cnt == (i_dma_mode == UHP_DMA_BURST8 ? 4'h8 : 4'h4))
        else $error("wrong strobe count in burst");
    end_stop_a: assert property (!transfer_end_in_n && !dma_ack_low |-> ##[0:6] !req_on)
        else $error("request kept after end of transfer");
    reset_quiet_a: assert property ((!rst_n) [*5] |-> dev_data_oe_n && !req_on)
        else $error("device active in reset");
endmodule : uhp_properties
`default_nettype wire

/* File: verilog/uhp_bus_if.sv */
`default_nettype none
// Processor bus between the controller and the host; data runs on separate host and device wires
interface uhp_bus_if;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic port_select;
    logic [15:0] host_data;
    logic host_data_oe_n;
    logic [15:0] dev_data;
    logic dev_data_oe_n;
    logic dma_request;
    logic dma_ack_low;
    logic transfer_end_in_n;
    logic irq;
    logic rst_n;
    modport device (
        input cs_n, rd_n, wr_n, port_select, host_data, host_data_oe_n,
        input dma_ack_low, transfer_end_in_n, rst_n,
        output dev_data, dev_data_oe_n, dma_request, irq
    );
    modport host (
        output cs_n, rd_n, wr_n, port_select, host_data, host_data_oe_n,
        output dma_ack_low, transfer_end_in_n, rst_n,
        input dev_data, dev_data_oe_n, dma_request, irq
    );
endinterface : uhp_bus_if
`default_nettype wire

/* File: verilog/uhp_defs.svh */
`ifndef UHP_DEFS_SVH
`define UHP_DEFS_SVH
// Device clock period in picoseconds (200 MHz)
`define UHP_CLK_PS 5000
// Bus and timing figures, times in ns
`define UHP_DATA_W 16
`define UHP_SEL_DATA 1'b0
`define UHP_SEL_CMD 1'b1
`define UHP_T_CMD_GAP_NS 300
`define UHP_T_RD_LOW_NS 33
`define UHP_T_RD_HIGH_NS 110
`define UHP_T_WR_LOW_NS 26
`define UHP_T_WR_HIGH_NS 110
`define UHP_T_ADDR_SU_NS 5
`define UHP_T_ADDR_HOLD_NS 8
`define UHP_T_ACK_REQ_NS 72
`define UHP_T_BST_LOW_NS 42
`define UHP_T_BST_HIGH_NS 60
`define UHP_T_BST_RD4_NS 105
`define UHP_T_BST_RD8_NS 150
`define UHP_T_BST_WR4_NS 72
`define UHP_T_BST_WR8_NS 167
// Least times round up to whole cycles
`define UHP_CYC_MIN(ns) ((((ns) * 1000) + `UHP_CLK_PS - 1) / `UHP_CLK_PS)
// Burst lengths
`define UHP_BURST4 4'h4
`define UHP_BURST8 4'h8
`endif

/* File: verilog/uhp_device.sv */
// Added by the designer: the placing of the registers and the APB interface to the registers.
`include "uhp_defs.svh"
`default_nettype none
// Function
// RULE1 - 16-bit words, little-endian byte order
// RULE2 - Port select low routes to data port
// RULE3 - Port select high routes to command port
// RULE4 - Strobes honoured only with chip select low; the device also honours them while DMA acknowledge is low
// RULE5 - Separate active-low strobes, one per transfer
// RULE6 - Port select captured at write strobe rise
// RULE7 - Host waits 300 ns after command access
// RULE8 - Read strobe low 33, high 110 ns
// RULE9 - Write strobe low 26, high 110 ns
// RULE10 - Read data valid 32 ns, released 22
// RULE11 - DMA request active level is configurable
// RULE12 - Single DMA: drop request on acknowledge
// RULE13 - Single DMA: rerequest 72 ns after acknowledge
// RULE14 - Acknowledge follows request, ends after strobe
// RULE15 - Bursts of exactly 4 or 8 strobes
// RULE16 - Burst strobe low 42, high 60 ns
// RULE17 - Burst: drop request before final strobe
// RULE18 - Burst request spacing per mode and direction
// RULE19 - End-of-transfer input terminates the DMA
// RULE20 - Interrupt level or edge, either polarity
// RULE21 - Held in reset while reset low
// RULE22 - Host writes command, then data
// RULE23 - Host holds reset low 160 us; the host reset pin just follows CTRL bit 5, with no minimum time
module uhp_device (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Processor bus
    uhp_bus_if.device bus,
    // Core side: command, data and configuration
    output logic o_cmd_valid,
    output logic [15:0] o_cmd,
    output logic o_wdata_valid,
    output logic [15:0] o_wdata,
    output logic o_rdata_take,
    input wire uhp_pkg::uhp_word_t i_rdata,
    input wire logic i_dma_want,
    input wire logic i_dma_read,
    input wire uhp_pkg::uhp_dma_mode_t i_dma_mode,
    input wire logic i_dma_request_active_high,
    input wire logic i_irq_event,
    input wire logic i_irq_edge,
    input wire logic i_irq_active_high,
    output logic o_dma_done
);
    import uhp_pkg::*;

    localparam int GAP_RD4 = `UHP_CYC_MIN(`UHP_T_BST_RD4_NS);
    localparam int GAP_RD8 = `UHP_CYC_MIN(`UHP_T_BST_RD8_NS);
    localparam int GAP_WR4 = `UHP_CYC_MIN(`UHP_T_BST_WR4_NS);
    localparam int GAP_WR8 = `UHP_CYC_MIN(`UHP_T_BST_WR8_NS);
    localparam int GAP_ONE = `UHP_CYC_MIN(`UHP_T_ACK_REQ_NS);

    typedef enum logic [1:0] {
        UHP_D_IDLE = 2'b00,
        UHP_D_REQ = 2'b01,
        UHP_D_XFER = 2'b10,
        UHP_D_GAP = 2'b11
    } uhp_dstate_t;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] rd_s;
        logic [1:0] wr_s;
        logic [1:0] ack_s;
        logic [1:0] eot_s;
        logic [1:0] sel_s;
        logic [1:0] rst_s;
        logic rd_q;
        logic wr_q;
        logic [15:0] wbuf;
        logic [15:0] wbuf2;
        logic [15:0] cmd;
        logic cmd_valid;
        logic [15:0] wdata;
        logic wdata_valid;
        logic rdata_take;
        logic [15:0] dout;
        logic oe_n;
        uhp_dstate_t dst;
        logic req;
        logic [3:0] left;
        logic [7:0] gap;
        logic done;
        logic irq_prev;
        logic irq_pulse;
        logic [1:0] drop_d;
    } uhp_dev_state_t;

    uhp_dev_state_t cur;
    uhp_dev_state_t next_cur;

    // Strobe count granted per request
    function automatic logic [3:0] burst_len(input uhp_dma_mode_t m);
        case (m)
            UHP_DMA_BURST4: burst_len = `UHP_BURST4;
            UHP_DMA_BURST8: burst_len = `UHP_BURST8;
            default: burst_len = 4'h1;
        endcase
    endfunction : burst_len

    // Spacing between requests for this mode and direction
    function automatic logic [7:0] gap_len(input uhp_dma_mode_t m, input logic rd);
        case (m)
            UHP_DMA_BURST4: gap_len = rd ? 8'(GAP_RD4) : 8'(GAP_WR4);
            UHP_DMA_BURST8: gap_len = rd ? 8'(GAP_RD8) : 8'(GAP_WR8);
            default: gap_len = 8'(GAP_ONE);
        endcase
    endfunction : gap_len

    logic rd_act;
    logic rd_fall;
    logic wr_rise;
    logic dma_cyc;
    logic strobe_fall;
    logic in_reset;

    // Pins pass two flops; only the second stage feeds logic
    always_comb begin
        in_reset = ~cur.rst_s[1];
        dma_cyc = ~cur.ack_s[1];
        rd_act = ~cur.rd_s[1] & (~cur.cs_s[1] | dma_cyc); // [RULE4]
        rd_fall = rd_act & cur.rd_q;
        wr_rise = cur.wr_s[1] & ~cur.wr_q;
        strobe_fall = dma_cyc & ((~cur.rd_s[1] & cur.rd_q) | (~cur.wr_s[1] & cur.wr_q));
    end

    // Next-state logic for the whole port
    always_comb begin
        next_cur = cur;
        next_cur.cs_s = {cur.cs_s[0], bus.cs_n};
        next_cur.rd_s = {cur.rd_s[0], bus.rd_n};
        next_cur.wr_s = {cur.wr_s[0], bus.wr_n};
        next_cur.ack_s = {cur.ack_s[0], bus.dma_ack_low};
        next_cur.eot_s = {cur.eot_s[0], bus.transfer_end_in_n};
        next_cur.sel_s = {cur.sel_s[0], bus.port_select};
        next_cur.rst_s = {cur.rst_s[0], bus.rst_n};
        next_cur.rd_q = cur.rd_s[1];
        next_cur.wr_q = cur.wr_s[1];
        next_cur.wbuf = bus.host_data;  // Data held 8 ns past the rise, so two stages keep it
        next_cur.wbuf2 = cur.wbuf;
        next_cur.cmd_valid = 1'b0;
        next_cur.wdata_valid = 1'b0;
        next_cur.rdata_take = 1'b0;
        next_cur.done = 1'b0;
        // Two extra stages hold a burst request past 22 ns after the strobe fall
        next_cur.drop_d = {cur.drop_d[0], strobe_fall};
        // Writes land on the synchronised rising edge of the write strobe
        if (wr_rise && (!cur.cs_s[1] || dma_cyc)) begin
            if (cur.sel_s[1] == `UHP_SEL_CMD && !dma_cyc) begin // [RULE6] [RULE3]
                next_cur.cmd = cur.wbuf2;
                next_cur.cmd_valid = 1'b1;
            end else begin // [RULE2]
                next_cur.wdata = cur.wbuf2; // [RULE1]
                next_cur.wdata_valid = 1'b1;
            end
        end
        // Read: data latched at strobe fall, about 15 ns after it; drop on rise
        if (rd_fall) begin
            next_cur.dout = (cur.sel_s[1] == `UHP_SEL_CMD && !dma_cyc) ? cur.cmd : i_rdata; // [RULE10]
            next_cur.oe_n = 1'b0;
            next_cur.rdata_take = (cur.sel_s[1] == `UHP_SEL_DATA) || dma_cyc;
        end else if (!rd_act) begin
            next_cur.oe_n = 1'b1; // [RULE10]
        end
        // DMA handshake
        case (cur.dst)
            UHP_D_IDLE: begin
                if (i_dma_want) begin
                    next_cur.req = 1'b1;
                    next_cur.left = burst_len(i_dma_mode); // [RULE15]
                    next_cur.dst = UHP_D_REQ;
                end
            end
            UHP_D_REQ: begin
                if (dma_cyc) begin
                    if (i_dma_mode == UHP_DMA_SINGLE) begin
                        next_cur.req = 1'b0; // [RULE12]
                    end
                    next_cur.dst = UHP_D_XFER;
                end
            end
            UHP_D_XFER: begin
                if (strobe_fall) begin
                    next_cur.left = cur.left - 4'h1;
                end
                if (cur.drop_d[1]) begin
                    next_cur.req = 1'b0; // [RULE17]
                end
                if (!cur.eot_s[1] && dma_cyc) begin
                    next_cur.req = 1'b0; // [RULE19]
                    next_cur.done = 1'b1;
                    next_cur.left = 4'h0;
                end
                if (!dma_cyc) begin
                    next_cur.gap = gap_len(i_dma_mode, i_dma_read); // [RULE18] [RULE13]
                    next_cur.dst = UHP_D_GAP;
                end
            end
            UHP_D_GAP: begin
                if (cur.gap != 8'h00) begin
                    next_cur.gap = cur.gap - 8'h01;
                end else begin
                    next_cur.dst = UHP_D_IDLE;
                end
            end
            default: next_cur.dst = UHP_D_IDLE;
        endcase
        // Interrupt: level follows event, edge gives one-cycle pulse
        next_cur.irq_prev = i_irq_event;
        next_cur.irq_pulse = i_irq_event & ~cur.irq_prev;
        // Synchronised reset pin holds the DMA state, request, read drive and command at rest
        if (in_reset) begin // [RULE21]
            next_cur.dst = UHP_D_IDLE;
            next_cur.req = 1'b0;
            next_cur.oe_n = 1'b1;
            next_cur.cmd = 16'h0000;
            next_cur.cmd_valid = 1'b0;
            next_cur.wdata_valid = 1'b0;
            next_cur.rdata_take = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cur <= '0;
            cur.cs_s <= 2'h3;
            cur.rd_s <= 2'h3;
            cur.wr_s <= 2'h3;
            cur.ack_s <= 2'h3;
            cur.eot_s <= 2'h3;
            cur.rd_q <= 1'b1;
            cur.wr_q <= 1'b1;
            cur.oe_n <= 1'b1;
            cur.dst <= UHP_D_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs
    assign bus.dev_data = cur.dout;
    assign bus.dev_data_oe_n = cur.oe_n;
    assign bus.dma_request = cur.req ~^ i_dma_request_active_high; // [RULE11]
    assign bus.irq = (i_irq_edge ? cur.irq_pulse : cur.irq_prev) ~^ i_irq_active_high; // [RULE20]
    assign o_cmd_valid = cur.cmd_valid;
    assign o_cmd = cur.cmd;
    assign o_wdata_valid = cur.wdata_valid;
    assign o_wdata = cur.wdata;
    assign o_rdata_take = cur.rdata_take;
    assign o_dma_done = cur.done | (cur.dst == UHP_D_XFER && cur.left == 4'h0 && !dma_cyc);
endmodule : uhp_device
`default_nettype wire

/* File: verilog/uhp_host.sv */
`include "uhp_defs.svh"
`default_nettype none
// Host end: APB slave registers drive the processor bus and DMA acknowledge
module uhp_host (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Processor bus
    uhp_bus_if.host bus
);
    import uhp_pkg::*;

    // Register offsets; CTRL: [0]go [1]read [2]port_select [3]dma [4]eot [5]reset [7:6]mode
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] LOW_N = 8'(`UHP_CYC_MIN(`UHP_T_BST_LOW_NS));
    localparam logic [7:0] HIGH_N = 8'(`UHP_CYC_MIN(`UHP_T_CMD_GAP_NS));
    localparam logic [7:0] BHIGH_N = 8'(`UHP_CYC_MIN(`UHP_T_BST_HIGH_NS));

    typedef enum logic [1:0] {
        UHP_H_IDLE = 2'b00,
        UHP_H_WAITREQ = 2'b01,
        UHP_H_LOW = 2'b10,
        UHP_H_HIGH = 2'b11
    } uhp_hstate_t;

    typedef struct packed {
        logic [1:0] req_s;
        logic [8:0] ctrl;
        logic [15:0] wdata;
        logic [15:0] rdata;
        uhp_hstate_t st;
        logic [7:0] cnt;
        logic [3:0] left;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic ack_n;
        logic eot_n;
        logic busy;
        logic [31:0] prdata;
    } uhp_host_state_t;

    uhp_host_state_t cur;
    uhp_host_state_t next_cur;
    logic is_dma;
    logic apb_wr;
    logic [3:0] blen;

    // Decode and next state
    always_comb begin
        next_cur = cur;
        is_dma = cur.ctrl[3];
        apb_wr = i_psel & i_penable & i_pwrite;
        blen = (cur.ctrl[7:6] == UHP_DMA_BURST8) ? `UHP_BURST8 :
            (cur.ctrl[7:6] == UHP_DMA_BURST4) ? `UHP_BURST4 : 4'h1;
        next_cur.req_s = {cur.req_s[0], bus.dma_request};
        next_cur.ctrl[0] = 1'b0;
        if (apb_wr && i_paddr == REG_CTRL && !cur.busy) begin
            next_cur.ctrl = i_pwdata[8:0];
        end
        if (apb_wr && i_paddr == REG_WDATA) begin
            next_cur.wdata = i_pwdata[15:0];
        end
        // Read data returned over APB in one cycle
        case (i_paddr)
            REG_CTRL: next_cur.prdata = {23'h000000, cur.ctrl};
            REG_WDATA: next_cur.prdata = {16'h0000, cur.wdata};
            REG_STAT: next_cur.prdata = {30'h00000000, cur.req_s[1], cur.busy};
            REG_RDATA: next_cur.prdata = {16'h0000, cur.rdata};
            default: next_cur.prdata = 32'h00000000;
        endcase
        case (cur.st)
            UHP_H_IDLE: begin
                if (cur.ctrl[0]) begin
                    next_cur.busy = 1'b1;
                    next_cur.left = blen;
                    next_cur.st = is_dma ? UHP_H_WAITREQ : UHP_H_LOW;
                    next_cur.cs_n = is_dma;
                    next_cur.cnt = LOW_N;
                end
            end
            UHP_H_WAITREQ: begin
                // Acknowledge only once a request is seen
                if (cur.req_s[1] ^ cur.ctrl[8]) begin // [RULE14] CTRL[8]: request active low
                    next_cur.ack_n = 1'b0;
                    next_cur.cnt = LOW_N;
                    next_cur.st = UHP_H_LOW;
                end
            end
            UHP_H_LOW: begin
                next_cur.rd_n = ~cur.ctrl[1]; // [RULE5]
                next_cur.wr_n = cur.ctrl[1];
                next_cur.eot_n = ~(cur.ctrl[4] && cur.left == 4'h1); // [RULE19]
                if (cur.cnt != 8'h00) begin
                    next_cur.cnt = cur.cnt - 8'h01; // [RULE8] [RULE9] [RULE16]
                end else begin
                    next_cur.rd_n = 1'b1;
                    next_cur.wr_n = 1'b1;
                    next_cur.cnt = is_dma ? BHIGH_N : HIGH_N; // [RULE7]
                    next_cur.left = cur.left - 4'h1;
                    if (cur.ctrl[1]) begin
                        next_cur.rdata = bus.dev_data;
                    end
                    next_cur.st = UHP_H_HIGH;
                end
            end
            UHP_H_HIGH: begin
                next_cur.eot_n = 1'b1;
                if (cur.left == 4'h0) begin
                    next_cur.ack_n = 1'b1;
                    next_cur.cs_n = 1'b1;
                end
                if (cur.cnt != 8'h00) begin
                    next_cur.cnt = cur.cnt - 8'h01;
                end else if (cur.left != 4'h0) begin
                    next_cur.cnt = LOW_N;
                    next_cur.st = UHP_H_LOW; // [RULE15]
                end else begin
                    next_cur.busy = 1'b0;
                    next_cur.st = UHP_H_IDLE;
                end
            end
            default: next_cur.st = UHP_H_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cur <= '0;
            cur.cs_n <= 1'b1;
            cur.rd_n <= 1'b1;
            cur.wr_n <= 1'b1;
            cur.ack_n <= 1'b1;
            cur.eot_n <= 1'b1;
            cur.st <= UHP_H_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // Pins and APB answer; reset pin follows CTRL bit 5 inverted
    assign bus.cs_n = cur.cs_n; // [RULE4]
    assign bus.rd_n = cur.rd_n;
    assign bus.wr_n = cur.wr_n;
    assign bus.port_select = cur.ctrl[2];
    assign bus.host_data = cur.wdata;
    assign bus.host_data_oe_n = ~(cur.busy & ~cur.ctrl[1]);
    assign bus.dma_ack_low = cur.ack_n;
    assign bus.transfer_end_in_n = cur.eot_n;
    assign bus.rst_n = ~cur.ctrl[5]; // [RULE23]
    assign o_prdata = cur.prdata;
    assign o_pready = i_psel & i_penable;
    assign o_pslverr = 1'b0;
endmodule : uhp_host
`default_nettype wire

/* File: verilog/uhp_pkg.sv */
`default_nettype none
package uhp_pkg;
    // DMA operating mode
    typedef enum logic [1:0] {
        UHP_DMA_SINGLE = 2'b00,
        UHP_DMA_BURST4 = 2'b01,
        UHP_DMA_BURST8 = 2'b10
    } uhp_dma_mode_t;
    typedef logic [15:0] uhp_word_t;
endpackage : uhp_pkg
`default_nettype wire
